// *** rtl/hpsr_device.sv ***
// Purpose: Device end: slot status, control and common registers behind the link.
// Assumes: Trip inputs are asynchronous pins; the link is on sys_clk.
// Notes:   A request is answered with ack one cycle after it is taken.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/10ps

module hpsr_device (
	// Clock and reset.
	input  wire logic                           sys_clk,
	input  wire logic                           resetn,
	// Link to the host.
	hpsr_link_if.device                         lnk,
	// Circuit breaker trip pins, one per supply.
	input  wire logic [hpsr_pkg::HPSR_OC_W-1:0] slot_a_trip,
	input  wire logic [hpsr_pkg::HPSR_OC_W-1:0] slot_b_trip,
	// Supply switch enables.
	output logic                                slot_a_primary_on,
	output logic                                slot_a_standby_on,
	output logic                                slot_b_primary_on,
	output logic                                slot_b_standby_on
);
	import hpsr_pkg::*;

	localparam int S = HPSR_SLOTS;

	// Two-stage synchronisers for the asynchronous pins.
	logic [HPSR_OC_W-1:0] trip_meta_q [S];
	logic [HPSR_OC_W-1:0] trip_sync_q [S];
	logic [S-1:0]         pin_meta_q;
	logic [S-1:0]         pin_sync_q;
	logic [HPSR_OC_W-1:0] trip_raw    [S];
	logic [S-1:0]         pin_raw;

	// Register state.
	logic [1:0]           ctrl_q [S];
	logic                 mask_q;
	logic                 ack_q;
	logic [7:0]           rdata_q;
	logic [S-1:0]         fault_oe_n_q;
	logic                 irq_oe_n_q;

	// Per-slot wiring.
	logic [7:0]           status  [S];
	logic [HPSR_OC_W-1:0] clear   [S];
	logic [S-1:0]         pri_hw;
	logic [S-1:0]         stb_hw;
	logic [S-1:0]         pri_on;
	logic [S-1:0]         stb_on;
	logic [S-1:0]         fdrive;
	logic [S-1:0]         pending;

	// Decode.
	logic                 take;
	logic                 wr_take;
	logic                 hit_ctrl_a;
	logic                 hit_ctrl_b;
	logic                 hit_stat_a;
	logic                 hit_stat_b;
	logic                 hit_common;
	logic [7:0]           ctrl_rd [S];
	logic [7:0]           common_rd;
	logic [7:0]           rd_mux;
	logic                 irq_active;

	assign trip_raw[0] = slot_a_trip;
	assign trip_raw[1] = slot_b_trip;
	assign pin_raw     = {lnk.slot_b_fault_pin_n, lnk.slot_a_fault_pin_n};
	assign pri_hw      = {lnk.slot_b_primary_hw_en, lnk.slot_a_primary_hw_en};
	assign stb_hw      = {lnk.slot_b_standby_hw_en, lnk.slot_a_standby_hw_en};

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pin_meta_q <= '1;
			pin_sync_q <= '1;
		end else begin
			pin_meta_q <= pin_raw;
			pin_sync_q <= pin_meta_q;
		end
	end

	// A request is taken on the edge where req is high and no answer is pending.
	assign take       = lnk.req & ~ack_q;
	assign wr_take    = take & lnk.we;
	assign hit_ctrl_a = lnk.cmd == HPSR_CMD_CTRL_A;
	assign hit_ctrl_b = lnk.cmd == HPSR_CMD_CTRL_B;
	assign hit_stat_a = lnk.cmd == HPSR_CMD_STAT_A;
	assign hit_stat_b = lnk.cmd == HPSR_CMD_STAT_B;
	assign hit_common = lnk.cmd == HPSR_CMD_COMMON;

	// Only the flag field of a status write acts, as a write-one clear.
	assign clear[0] = (wr_take & hit_stat_a) ? lnk.wdata[HPSR_OC_W-1:0] : '0;
	assign clear[1] = (wr_take & hit_stat_b) ? lnk.wdata[HPSR_OC_W-1:0] : '0;

	genvar g;
	generate
		for (g = 0; g < S; g++) begin : g_slot
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					trip_meta_q[g] <= '0;
					trip_sync_q[g] <= '0;
				end else begin
					trip_meta_q[g] <= trip_raw[g];
					trip_sync_q[g] <= trip_meta_q[g];
				end
			end

			hpsr_slot_status u_slot (
				.sys_clk          (sys_clk),
				.resetn           (resetn),
				.oc_trip          (trip_sync_q[g]),
				.primary_hw_en    (pri_hw[g]),
				.standby_hw_en    (stb_hw[g]),
				.ctrl_primary     (ctrl_q[g][HPSR_CTRL_PRI]),
				.ctrl_standby     (ctrl_q[g][HPSR_CTRL_STB]),
				.fault_pin_n_sync (pin_sync_q[g]),
				.oc_clear         (clear[g]),
				.status           (status[g]),
				.primary_on       (pri_on[g]),
				.standby_on       (stb_on[g]),
				.fault_drive      (fdrive[g]),
				.oc_pending       (pending[g])
			);

			always_comb begin
				ctrl_rd[g]                   = HPSR_CTRL_RESET;
				ctrl_rd[g][HPSR_CTRL_PG_STB] = stb_on[g];
				ctrl_rd[g][HPSR_CTRL_PG_PRI] = pri_on[g];
				ctrl_rd[g][1:0]              = ctrl_q[g];
			end
		end
	endgenerate

	always_comb begin
		common_rd                = HPSR_UNMAPPED;
		common_rd[HPSR_MASK_BIT] = mask_q;
	end

	assign rd_mux = hit_ctrl_a ? ctrl_rd[0] :
	                hit_ctrl_b ? ctrl_rd[1] :
	                hit_stat_a ? status[0]  :
	                hit_stat_b ? status[1]  :
	                hit_common ? common_rd  : HPSR_UNMAPPED;

	// A clear from the host drops the flag, so the interrupt follows it out.
	assign irq_active = (|pending) & ~mask_q;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ack_q   <= 1'b0;
			rdata_q <= HPSR_STAT_RESET;
		end else begin
			ack_q <= take;
			if (take) begin
				rdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q[0] <= HPSR_CTRL_RESET[1:0];
			ctrl_q[1] <= HPSR_CTRL_RESET[1:0];
			mask_q    <= HPSR_MASK_RESET;
		end else if (wr_take) begin
			if (hit_ctrl_a) begin
				ctrl_q[0] <= lnk.wdata[1:0];
			end
			if (hit_ctrl_b) begin
				ctrl_q[1] <= lnk.wdata[1:0];
			end
			if (hit_common) begin
				mask_q <= lnk.wdata[HPSR_MASK_BIT];
			end
		end
	end

	// Open-drain drivers: enable low pulls the wire low.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fault_oe_n_q <= '1;
			irq_oe_n_q   <= 1'b1;
		end else begin
			fault_oe_n_q <= ~fdrive;
			irq_oe_n_q   <= ~irq_active;
		end
	end

	assign lnk.ack               = ack_q;
	assign lnk.rdata             = rdata_q;
	assign lnk.slot_a_fault_out  = 1'b0;
	assign lnk.slot_b_fault_out  = 1'b0;
	assign lnk.slot_a_fault_oe_n = fault_oe_n_q[0];
	assign lnk.slot_b_fault_oe_n = fault_oe_n_q[1];
	assign lnk.irq_out           = 1'b0;
	assign lnk.irq_oe_n          = irq_oe_n_q;

	assign slot_a_primary_on = pri_on[0];
	assign slot_a_standby_on = stb_on[0];
	assign slot_b_primary_on = pri_on[1];
	assign slot_b_standby_on = stb_on[1];

endmodule : hpsr_device

// *** rtl/hpsr_host.sv ***
// Purpose: Host end: Avalon-MM registers that issue link transfers and drive enables.
// Assumes: Pins from the device end are logic on the same sys_clk.
// Notes:   A command write stalls with waitrequest while a transfer is in flight.
`timescale 1ns/10ps

module hpsr_host (
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	// Avalon-MM slave.
	input  wire logic [1:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Link to the device.
	hpsr_link_if.host        lnk
);
	import hpsr_pkg::*;

	hpsr_host_state_type state_q;
	logic                req_q;
	logic                we_q;
	logic [7:0]          cmd_q;
	logic [7:0]          wdata_q;
	logic [7:0]          rdata_q;
	logic [3:0]          en_q;
	logic                av_ack_q;
	logic [31:0]         readdata_q;
	logic                access;
	logic                stall;
	logic                cmd_wr;
	logic                en_wr;
	logic [31:0]         rd_mux;

	assign access          = avs_read | avs_write;
	assign stall           = avs_write & (avs_address == HPSR_AV_CMD) & req_q;
	assign avs_waitrequest = access & ~av_ack_q;
	assign cmd_wr          = av_ack_q & avs_write & (avs_address == HPSR_AV_CMD);
	assign en_wr           = av_ack_q & avs_write & (avs_address == HPSR_AV_PINS);

	always_comb begin
		rd_mux = '0;
		unique case (avs_address)
			HPSR_AV_CMD: begin
				rd_mux[7:0]                         = cmd_q;
				rd_mux[HPSR_AV_WD_LSB +: 8]         = wdata_q;
				rd_mux[HPSR_AV_WE_BIT]              = we_q;
			end
			HPSR_AV_RESULT: begin
				rd_mux[7:0]                         = rdata_q;
				rd_mux[HPSR_AV_BUSY_BIT]            = req_q;
			end
			HPSR_AV_PINS: begin
				rd_mux[3:0]                         = en_q;
				rd_mux[HPSR_AV_PIN_LSB +: 3]        = {lnk.irq_n, lnk.slot_b_fault_pin_n,
				                                       lnk.slot_a_fault_pin_n};
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			av_ack_q   <= 1'b0;
			readdata_q <= '0;
		end else begin
			av_ack_q <= access & ~av_ack_q & ~stall;
			if (access & ~av_ack_q & ~stall) begin
				readdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= HPSR_HOST_IDLE;
			req_q   <= 1'b0;
			we_q    <= 1'b0;
			cmd_q   <= '0;
			wdata_q <= '0;
			rdata_q <= '0;
		end else begin
			unique case (state_q)
				HPSR_HOST_IDLE: begin
					if (cmd_wr) begin
						cmd_q   <= avs_writedata[7:0];
						wdata_q <= avs_writedata[HPSR_AV_WD_LSB +: 8];
						we_q    <= avs_writedata[HPSR_AV_WE_BIT];
						req_q   <= 1'b1;
						state_q <= HPSR_HOST_WAIT;
					end
				end
				HPSR_HOST_WAIT: begin
					if (lnk.ack) begin
						rdata_q <= lnk.rdata;
						req_q   <= 1'b0;
						state_q <= HPSR_HOST_IDLE;
					end
				end
			endcase
		end
	end

	// Software keeps both enables of a register-powered slot low.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			en_q <= HPSR_EN_RESET;
		end else if (en_wr) begin
			en_q <= avs_writedata[3:0];
		end
	end

	assign avs_readdata             = readdata_q;
	assign lnk.req                  = req_q;
	assign lnk.we                   = we_q;
	assign lnk.cmd                  = cmd_q;
	assign lnk.wdata                = wdata_q;
	assign lnk.slot_a_primary_hw_en = en_q[0];
	assign lnk.slot_a_standby_hw_en = en_q[1];
	assign lnk.slot_b_primary_hw_en = en_q[2];
	assign lnk.slot_b_standby_hw_en = en_q[3];

endmodule : hpsr_host

// *** rtl/hpsr_link_if.sv ***
// Purpose: Link between host end and device end, with open-drain pins resolved.
// Assumes: Both ends run on the same sys_clk.
// Notes:   An open-drain wire floats high through an assumed pull-up.
`timescale 1ns/10ps

interface hpsr_link_if (
	input wire logic sys_clk
);
	logic       req;
	logic       we;
	logic [7:0] cmd;
	logic [7:0] wdata;
	logic       ack;
	logic [7:0] rdata;
	logic       slot_a_primary_hw_en;
	logic       slot_a_standby_hw_en;
	logic       slot_b_primary_hw_en;
	logic       slot_b_standby_hw_en;
	logic       slot_a_fault_out;
	logic       slot_a_fault_oe_n;
	logic       slot_b_fault_out;
	logic       slot_b_fault_oe_n;
	logic       irq_out;
	logic       irq_oe_n;
	logic       slot_a_fault_pin_n;
	logic       slot_b_fault_pin_n;
	logic       irq_n;

	assign slot_a_fault_pin_n = slot_a_fault_oe_n ? 1'b1 : slot_a_fault_out;
	assign slot_b_fault_pin_n = slot_b_fault_oe_n ? 1'b1 : slot_b_fault_out;
	assign irq_n              = irq_oe_n ? 1'b1 : irq_out;

	modport device (
		input  req, we, cmd, wdata,
		input  slot_a_primary_hw_en, slot_a_standby_hw_en,
		input  slot_b_primary_hw_en, slot_b_standby_hw_en,
		input  slot_a_fault_pin_n, slot_b_fault_pin_n,
		output ack, rdata,
		output slot_a_fault_out, slot_a_fault_oe_n,
		output slot_b_fault_out, slot_b_fault_oe_n,
		output irq_out, irq_oe_n
	);

	modport host (
		output req, we, cmd, wdata,
		output slot_a_primary_hw_en, slot_a_standby_hw_en,
		output slot_b_primary_hw_en, slot_b_standby_hw_en,
		input  ack, rdata,
		input  slot_a_fault_pin_n, slot_b_fault_pin_n, irq_n
	);
endinterface : hpsr_link_if

// *** rtl/hpsr_pkg.sv ***
// Purpose: Constants and types shared by both ends of the slot status link.
// Assumes: One clock, sys_clk at 250 MHz, for both ends.
// Notes:   The host end is an Avalon-MM slave with its own small register map.
//
// Functional notes
// - Status byte: fault, primary, standby, five flags.
// - Fault bit is one while fault pin low.
// - Primary bit shows actual primary supplies state.
// - Standby bit shows actual standby output state.
// - Overcurrent flag is one after own fault.
// - Power-up clears status, all outputs off.
// - Command 04h selects slot A, 05h B.
// - Writing one clears flag and releases interrupt.
// - Reads and clears never touch fault pin.
// - Primary fault held until primary enable low.
// - Standby fault held until standby enable low.
// - Both faults need both enables low.
// - Register powered slot keeps fault inactive.
// - Register powered slot: enable inputs held low.
// - Slot B is an identical independent copy.
// - Control register bits switch primary and standby.
// - Mask bit zero enables interrupt, one blocks.

package hpsr_pkg;

	localparam int          HPSR_SLOTS       = 2;
	localparam int          HPSR_OC_W        = 5;

	localparam logic [7:0]  HPSR_CMD_CTRL_A  = 8'h02;
	localparam logic [7:0]  HPSR_CMD_CTRL_B  = 8'h03;
	localparam logic [7:0]  HPSR_CMD_STAT_A  = 8'h04;
	localparam logic [7:0]  HPSR_CMD_STAT_B  = 8'h05;
	localparam logic [7:0]  HPSR_CMD_COMMON  = 8'h06;

	localparam logic [7:0]  HPSR_STAT_RESET  = 8'h00;
	localparam logic [7:0]  HPSR_CTRL_RESET  = 8'h00;
	localparam logic [7:0]  HPSR_UNMAPPED    = 8'h00;

	localparam int          HPSR_FAULT_BIT   = 7;
	localparam int          HPSR_PRIMARY_BIT = 6;
	localparam int          HPSR_STANDBY_BIT = 5;
	localparam int          HPSR_OC_STANDBY  = 4;
	localparam int          HPSR_OC_NEG12    = 3;
	localparam int          HPSR_OC_POS12    = 2;
	localparam int          HPSR_OC_FIVE     = 1;
	localparam int          HPSR_OC_THREE    = 0;
	localparam logic [4:0]  HPSR_PRIMARY_OC  = 5'h0F;

	localparam int          HPSR_CTRL_PRI    = 1;
	localparam int          HPSR_CTRL_STB    = 0;
	localparam int          HPSR_CTRL_PG_PRI = 6;
	localparam int          HPSR_CTRL_PG_STB = 7;
	localparam int          HPSR_MASK_BIT    = 3;
	localparam logic        HPSR_MASK_RESET  = 1'b0;

	localparam logic [1:0]  HPSR_AV_CMD      = 2'h0;
	localparam logic [1:0]  HPSR_AV_RESULT   = 2'h1;
	localparam logic [1:0]  HPSR_AV_PINS     = 2'h2;
	localparam int          HPSR_AV_WD_LSB   = 8;
	localparam int          HPSR_AV_WE_BIT   = 16;
	localparam int          HPSR_AV_BUSY_BIT = 8;
	localparam int          HPSR_AV_PIN_LSB  = 4;
	localparam logic [3:0]  HPSR_EN_RESET    = 4'h0;

	typedef enum logic {
		HPSR_HOST_IDLE,
		HPSR_HOST_WAIT
	} hpsr_host_state_type;

endpackage : hpsr_pkg

// *** rtl/hpsr_slot_status.sv ***
// Purpose: One slot's overcurrent flags, fault latches and power state.
// Assumes: Trip and fault pin inputs are already synchronised.
// Notes:   Instantiated once for each slot by the device end.
`timescale 1ns/10ps

module hpsr_slot_status (
	// Clock and reset.
	input  wire logic                         sys_clk,
	input  wire logic                         resetn,
	// Slot inputs.
	input  wire logic [hpsr_pkg::HPSR_OC_W-1:0] oc_trip,
	input  wire logic                         primary_hw_en,
	input  wire logic                         standby_hw_en,
	input  wire logic                         ctrl_primary,
	input  wire logic                         ctrl_standby,
	input  wire logic                         fault_pin_n_sync,
	input  wire logic [hpsr_pkg::HPSR_OC_W-1:0] oc_clear,
	// Slot state.
	output logic      [7:0]                   status,
	output logic                              primary_on,
	output logic                              standby_on,
	output logic                              fault_drive,
	output logic                              oc_pending
);
	import hpsr_pkg::*;

	logic [HPSR_OC_W-1:0] oc_q;
	logic [HPSR_OC_W-1:0] oc_d;
	logic                 pri_fault_q;
	logic                 pri_fault_d;
	logic                 stb_fault_q;
	logic                 stb_fault_d;
	logic                 pri_on_q;
	logic                 stb_on_q;
	logic                 pri_req;
	logic                 stb_req;
	logic                 pri_trip;
	logic                 stb_trip;
	logic                 reg_powered;

	assign pri_req     = primary_hw_en | ctrl_primary;
	assign stb_req     = standby_hw_en | ctrl_standby;
	assign reg_powered = ctrl_primary | ctrl_standby;
	assign pri_trip    = |(oc_trip & HPSR_PRIMARY_OC);
	assign stb_trip    = oc_trip[HPSR_OC_STANDBY];

	// A new trip wins over a clear in the same cycle.
	assign oc_d        = (oc_q & ~oc_clear) | oc_trip;
	// The trip latches drop only once the enable that powers the path goes low.
	assign pri_fault_d = pri_trip | (pri_fault_q & pri_req);
	assign stb_fault_d = stb_trip | (stb_fault_q & stb_req);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			oc_q        <= '0;
			pri_fault_q <= 1'b0;
			stb_fault_q <= 1'b0;
			pri_on_q    <= 1'b0;
			stb_on_q    <= 1'b0;
		end else begin
			oc_q        <= oc_d;
			pri_fault_q <= pri_fault_d;
			stb_fault_q <= stb_fault_d;
			pri_on_q    <= pri_req & ~pri_fault_d;
			stb_on_q    <= stb_req & ~stb_fault_d;
		end
	end

	// The pin stays low while either latch holds; register control suppresses it.
	assign fault_drive = (pri_fault_q | stb_fault_q) & ~reg_powered;
	assign primary_on  = pri_on_q;
	assign standby_on  = stb_on_q;
	assign oc_pending  = |oc_q;

	assign status[HPSR_FAULT_BIT]   = ~fault_pin_n_sync & ~reg_powered;
	assign status[HPSR_PRIMARY_BIT] = pri_on_q;
	assign status[HPSR_STANDBY_BIT] = stb_on_q;
	assign status[HPSR_OC_W-1:0]    = oc_q;

endmodule : hpsr_slot_status

// *** sim/hpsr_checker.sv ***
// Purpose: Concurrent checks on the link between the host end and the device end.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   Instantiated beside the link interface by the bench, without bind.
`timescale 1ns/10ps

module hpsr_checker (
	// Clock and reset.
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	// Link transfer.
	input  wire logic       req,
	input  wire logic       we,
	input  wire logic [7:0] cmd,
	input  wire logic [7:0] wdata,
	input  wire logic       ack,
	input  wire logic [7:0] rdata,
	// Enables and resolved open-drain wires.
	input  wire logic       slot_a_primary_hw_en,
	input  wire logic       slot_a_standby_hw_en,
	input  wire logic       slot_a_fault_pin_n,
	input  wire logic       slot_b_fault_pin_n,
	input  wire logic       irq_n
);
	import hpsr_pkg::*;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	a_ack_after_take: assert property (req && !ack |=> ack)
		else $error("ack missing one cycle after take");
	a_ack_one_cycle: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	a_req_held_stable: assert property (req && !ack |=>
		req && $stable(cmd) && $stable(we) && $stable(wdata))
		else $error("request changed before ack");
	a_req_released: assert property (ack |=> !req)
		else $error("request not released after ack");
	a_unmapped_zero: assert property (req && !ack && !we &&
		(cmd < HPSR_CMD_CTRL_A || cmd > HPSR_CMD_COMMON) |=> rdata == HPSR_UNMAPPED)
		else $error("unmapped command read not zero");

	// The fault bit reads the synchronised wire, so it is judged only when the wire has settled.
	sequence s_stat_a_read_settled;
		$stable(slot_a_fault_pin_n) [*3] ##0 (req && !ack && !we && cmd == HPSR_CMD_STAT_A);
	endsequence
	a_fault_bit_mirror: assert property (s_stat_a_read_settled |=>
		rdata[HPSR_FAULT_BIT] == !$past(slot_a_fault_pin_n))
		else $error("fault bit differs from fault wire");
	a_fault_held_en: assert property ($rose(slot_a_fault_pin_n) |-> !slot_a_primary_hw_en || !slot_a_standby_hw_en)
		else $error("fault wire released with enables high");
	a_access_keeps_pin: assert property (req && !ack && cmd == HPSR_CMD_STAT_A |=> $stable(slot_a_fault_pin_n))
		else $error("status access moved the fault wire");

	c_write_taken: cover property (req && !ack && we);
	c_fault_a_low: cover property ($fell(slot_a_fault_pin_n));
	c_fault_b_low: cover property ($fell(slot_b_fault_pin_n));
	c_irq_low: cover property ($fell(irq_n));
endmodule : hpsr_checker

// *** sim/test_hotplug_slot_status_regs.sv ***
// Purpose: Self-checking bench for both ends of the slot status link.
// Assumes: Both ends share sys_clk; reset is held for 16 cycles.
// Notes:   All link traffic and enables go through the host's Avalon-MM registers.
`timescale 1ns/10ps

module test_hotplug_slot_status_regs;
	import hpsr_pkg::*;
	logic        sys_clk       = 1'b0;
	logic        resetn        = 1'b0;
	logic [1:0]  avs_address   = 2'h0;
	logic        avs_read      = 1'b0;
	logic        avs_write     = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [4:0]  slot_a_trip   = 5'h00;
	logic [4:0]  slot_b_trip   = 5'h00;
	logic        a_pri_on, a_stb_on, b_pri_on, b_stb_on;
	int          errors        = 0;
	int          checked       = 0;
	int          cycles        = 0;
	logic [7:0]  rd;
	logic [31:0] r;

	always #2 sys_clk = ~sys_clk;

	hpsr_link_if hpsr_link_if_i (.sys_clk(sys_clk));
	hpsr_host hpsr_host_i (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .lnk(hpsr_link_if_i.host));
	hpsr_device hpsr_device_i (.sys_clk(sys_clk), .resetn(resetn), .lnk(hpsr_link_if_i.device),
		.slot_a_trip(slot_a_trip), .slot_b_trip(slot_b_trip), .slot_a_primary_on(a_pri_on),
		.slot_a_standby_on(a_stb_on), .slot_b_primary_on(b_pri_on), .slot_b_standby_on(b_stb_on));
	hpsr_checker hpsr_checker_i (.sys_clk(sys_clk), .resetn(resetn), .req(hpsr_link_if_i.req),
		.we(hpsr_link_if_i.we), .cmd(hpsr_link_if_i.cmd), .wdata(hpsr_link_if_i.wdata), .ack(hpsr_link_if_i.ack),
		.rdata(hpsr_link_if_i.rdata), .slot_a_primary_hw_en(hpsr_link_if_i.slot_a_primary_hw_en),
		.slot_a_standby_hw_en(hpsr_link_if_i.slot_a_standby_hw_en),
		.slot_a_fault_pin_n(hpsr_link_if_i.slot_a_fault_pin_n),
		.slot_b_fault_pin_n(hpsr_link_if_i.slot_b_fault_pin_n), .irq_n(hpsr_link_if_i.irq_n));

	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			complete_run();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One Avalon access, held until waitrequest is sampled low; only the bench timeout ends a hang.
	task automatic av(input logic wr, input logic [1:0] adr, input logic [31:0] wd, output logic [31:0] q);
		int   n;
		logic w1;
		@(posedge sys_clk);
		avs_address   <= adr;
		avs_writedata <= wd;
		avs_write     <= wr;
		avs_read      <= !wr;
		n  = 0;
		w1 = 1'b0;
		do begin
			@(posedge sys_clk);
			if (n == 0) begin
				w1 = avs_waitrequest;
			end
			n++;
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		chk("waitrequest", 32'h1, {31'h0, w1});
	endtask : av

	// One link transfer, then the result register is polled until not busy, at most 50 reads.
	task automatic link(input logic wr, input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] q);
		logic [31:0] w;
		int n;
		av(1'b1, HPSR_AV_CMD, {15'h0000, wr, wd, cmd}, w);
		n = 0;
		do begin
			av(1'b0, HPSR_AV_RESULT, 32'h0, w);
			n++;
		end while (w[HPSR_AV_BUSY_BIT] !== 1'b0 && n < 50);
		chk("busy", 32'h0, {31'h0, w[HPSR_AV_BUSY_BIT]});
		q = w[7:0];
	endtask : link

	task automatic expect_reg(input string what, input logic [7:0] cmd, input logic [7:0] exp);
		link(1'b0, cmd, 8'h00, rd);
		chk(what, exp, rd);
	endtask : expect_reg

	// Wire bits are irq, slot B fault, slot A fault, all active low.
	task automatic expect_wires(input logic [2:0] msk, input logic [2:0] exp);
		av(1'b0, HPSR_AV_PINS, 32'h0, r);
		chk("wires", exp, r[6:4] & msk);
	endtask : expect_wires

	task automatic set_en(input logic [3:0] e);
		av(1'b1, HPSR_AV_PINS, {28'h0, e}, r);
		repeat (10) @(posedge sys_clk);
	endtask : set_en

	task automatic trip(input logic [4:0] a, input logic [4:0] b);
		@(posedge sys_clk);
		slot_a_trip <= a;
		slot_b_trip <= b;
		repeat (4) @(posedge sys_clk);
		slot_a_trip <= 5'h00;
		slot_b_trip <= 5'h00;
		repeat (10) @(posedge sys_clk);
	endtask : trip

	task automatic t_reset;
		expect_reg("stat_a", HPSR_CMD_STAT_A, 8'h00);
		expect_reg("stat_b", HPSR_CMD_STAT_B, 8'h00);
		chk("supplies", 32'h0, {a_pri_on, a_stb_on, b_pri_on, b_stb_on});
		link(1'b1, 8'h07, 8'hFF, rd);
		expect_reg("cmd_07", 8'h07, 8'h00);
		av(1'b1, 2'h3, 32'hFFFFFFFF, r);
		av(1'b0, 2'h3, 32'h0, r);
		chk("av_unmapped", 32'h0, r);
		expect_wires(3'h7, 3'h7);
	endtask : t_reset

	task automatic t_flags;
		logic [7:0] m;
		logic [7:0] c;
		for (int s = 0; s < 2; s++) begin
			for (int i = 0; i < 5; i++) begin
				m = 8'h01 << i;
				c = s ? HPSR_CMD_STAT_B : HPSR_CMD_STAT_A;
				trip(s ? 5'h00 : m[4:0], s ? m[4:0] : 5'h00);
				expect_reg("flag_set", c, m);
				expect_reg("other_slot", c ^ 8'h01, 8'h00);
				expect_wires(3'h4, 3'h0);
				link(1'b1, c, 8'h00, rd);
				expect_reg("flag_kept", c, m);
				link(1'b1, c, m, rd);
				expect_reg("flag_clear", c, 8'h00);
				expect_wires(3'h4, 3'h4);
			end
		end
	endtask : t_flags

	task automatic t_hw_power;
		set_en(4'h3);
		expect_reg("a_on", HPSR_CMD_STAT_A, 8'h60);
		chk("a_out", 32'h3, {a_pri_on, a_stb_on});
		trip(5'h04, 5'h00);
		expect_reg("a_pri_trip", HPSR_CMD_STAT_A, 8'hA4);
		expect_wires(3'h7, 3'h2);
		link(1'b1, HPSR_CMD_STAT_A, 8'hE4, rd);
		expect_reg("a_cleared", HPSR_CMD_STAT_A, 8'hA0);
		expect_wires(3'h7, 3'h6);
		trip(5'h10, 5'h00);
		expect_reg("a_both", HPSR_CMD_STAT_A, 8'h90);
		link(1'b1, HPSR_CMD_STAT_A, 8'h10, rd);
		set_en(4'h2);
		expect_reg("a_one_low", HPSR_CMD_STAT_A, 8'h80);
		set_en(4'h0);
		expect_reg("a_both_low", HPSR_CMD_STAT_A, 8'h00);
		expect_wires(3'h7, 3'h7);
		set_en(4'h8);
		trip(5'h00, 5'h10);
		expect_reg("b_stb_trip", HPSR_CMD_STAT_B, 8'h90);
		expect_wires(3'h7, 3'h1);
		set_en(4'h0);
		expect_reg("b_stb_low", HPSR_CMD_STAT_B, 8'h10);
		link(1'b1, HPSR_CMD_STAT_B, 8'h10, rd);
	endtask : t_hw_power

	task automatic t_reg_power;
		link(1'b1, HPSR_CMD_CTRL_B, 8'h03, rd);
		repeat (10) @(posedge sys_clk);
		expect_reg("b_ctrl", HPSR_CMD_CTRL_B, 8'hC3);
		expect_reg("b_stat", HPSR_CMD_STAT_B, 8'h60);
		chk("b_out", 32'h3, {b_pri_on, b_stb_on});
		trip(5'h00, 5'h01);
		expect_reg("b_reg_trip", HPSR_CMD_STAT_B, 8'h21);
		expect_wires(3'h7, 3'h3);
		link(1'b1, HPSR_CMD_COMMON, 8'h08, rd);
		expect_reg("mask", HPSR_CMD_COMMON, 8'h08);
		expect_wires(3'h4, 3'h4);
		link(1'b1, HPSR_CMD_COMMON, 8'h00, rd);
		expect_wires(3'h4, 3'h0);
		link(1'b1, HPSR_CMD_STAT_B, 8'h01, rd);
		link(1'b1, HPSR_CMD_CTRL_B, 8'h00, rd);
		expect_wires(3'h7, 3'h7);
	endtask : t_reg_power

	initial begin
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		t_reset();
		t_flags();
		t_hw_power();
		t_reg_power();
		complete_run();
	end
endmodule : test_hotplug_slot_status_regs
